// *** ssw_regs.svh ***
// Constants for the supply supervisor and watchdog block
//
// Behaviour
// - Reset stays low while low-line is below threshold and for a stretch time after it recovers.
// - An enabled watchdog that is not serviced in time pulses reset low for a fixed duration.
// - A kick input held steady past the timeout pulses reset low and drives the fault output low.
// - Every kick input transition restarts the timeout; the processor must toggle it in time.
// - A floating or mid-supply kick input disables the watchdog, so no timeout reset or fault.
// - The supply-fail flag is low while the supply-fail sense is below threshold, else high.
// - While main supply is below the backup cell, the supply-fail flag is forced low.
// - Gated chip select follows its input while low-line is good and is forced high otherwise.
// - Main feeds the switched output when above the cell with low-line good; cell when both low.
// - The fault output returns high on the next kick transition or when low-line goes low.
// - The active-high reset output is always the inverse of the active-low reset output.
// - Timebase select high or open uses the internal oscillator, low uses the external input.
`ifndef SSW_REGS_SVH
`define SSW_REGS_SVH

// System clock period in ns (50 MHz)
`define SSW_CLK_NS 32'h14
// Internal oscillator tick period in us; plain default, adjust per build
`define SSW_INT_TICK_US 32'h3E8
// Reset stretch and watchdog pulse length in ms (50)
`define SSW_STRETCH_MS 32'h32
// Cycles per internal tick, a longest time so it rounds down
`define SSW_INT_DIV ((`SSW_INT_TICK_US * 32'h3E8) / `SSW_CLK_NS)
// Stretch in ticks, a least time so it rounds up
`define SSW_STRETCH_TICKS ((`SSW_STRETCH_MS * 32'h3E8 + `SSW_INT_TICK_US - 32'h1) / `SSW_INT_TICK_US)
// Watchdog timeout in ticks; plain default
`define SSW_WD_TIMEOUT_TICKS 32'h64

// Synchroniser bit positions
`define SSW_SYNC_W 8
`define SSW_IX_LL 0
`define SSW_IX_PF 1
`define SSW_IX_MAIN 2
`define SSW_IX_KHI 3
`define SSW_IX_KLO 4
`define SSW_IX_TSEL 5
`define SSW_IX_EXT 6
`define SSW_IX_CS 7
// Reset value of the settled inputs: timebase select open reads high, chip select idle high
`define SSW_STAB_RST 8'hA0

`define SSW_DIV_W 16
`define SSW_STR_W 8
`define SSW_WD_W 16

`endif

// *** ssw_pkg.sv ***
// Types of the supply supervisor and watchdog block
`include "ssw_regs.svh"

package ssw_pkg;

	typedef enum logic [1:0] {
		PH_HOLD = 2'b00,
		PH_STRETCH = 2'b01,
		PH_RUN = 2'b10,
		PH_WDPULSE = 2'b11
	} ssw_phase_type;

	typedef enum logic [1:0] {
		KICK_LOW = 2'b00,
		KICK_HIGH = 2'b01,
		KICK_MID = 2'b10
	} ssw_kick_type;

	typedef struct packed {
		logic reset_n;
		logic reset;
		logic fault_n;
		logic flag_n;
		logic cs_n;
		logic backup;
		logic low_line_n;
	} ssw_out_type;

	typedef struct packed {
		logic [`SSW_SYNC_W-1:0] s1;
		logic [`SSW_SYNC_W-1:0] s2;
		logic [`SSW_SYNC_W-1:0] s3;
		logic [`SSW_SYNC_W-1:0] stab;
		logic ext_prev;
		logic [`SSW_DIV_W-1:0] div_cnt;
		ssw_phase_type phase;
		logic [`SSW_STR_W-1:0] str_cnt;
		logic [`SSW_WD_W-1:0] wd_cnt;
		ssw_kick_type kick_prev;
		ssw_out_type out;
	} ssw_state_type;

endpackage : ssw_pkg

// *** ssw_supervisor.sv ***
// Supply supervisor: reset stretch, three-level watchdog, supply flags and gating
`timescale 1ns/10ps
`default_nettype none
`include "ssw_regs.svh"

module ssw_supervisor #(
	parameter logic [`SSW_DIV_W-1:0] INT_DIV = `SSW_DIV_W'(`SSW_INT_DIV),
	parameter logic [`SSW_STR_W-1:0] STRETCH_TICKS = `SSW_STR_W'(`SSW_STRETCH_TICKS),
	parameter logic [`SSW_WD_W-1:0] WD_TIMEOUT_TICKS = `SSW_WD_W'(`SSW_WD_TIMEOUT_TICKS)
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic low_line_sense_ok_i,
	input wire logic supply_fail_sense_ok_i,
	input wire logic main_above_backup_cell_i,
	input wire logic watchdog_kick_in_hi_i,
	input wire logic watchdog_kick_in_lo_i,
	input wire logic timebase_select_i,
	input wire logic external_timebase_in_i,
	input wire logic chip_select_n_i,
	output logic reset_n_o,
	output logic reset_o,
	output logic watchdog_fault_out_n_o,
	output logic supply_fail_flag_n_o,
	output logic chip_select_gated_n_o,
	output logic backup_active_o,
	output logic low_line_n_o
);

	// Two comparators resolve the three-level kick pin; both or neither means mid/open
	function automatic ssw_pkg::ssw_kick_type kick_level(input logic hi, input logic lo);
		if (hi && !lo) begin
			return ssw_pkg::KICK_HIGH;
		end
		if (lo && !hi) begin
			return ssw_pkg::KICK_LOW;
		end
		return ssw_pkg::KICK_MID;
	endfunction : kick_level

	localparam ssw_pkg::ssw_state_type RESET_STATE = '{
		s1: `SSW_STAB_RST,
		s2: `SSW_STAB_RST,
		s3: `SSW_STAB_RST,
		stab: `SSW_STAB_RST,
		ext_prev: 1'h0,
		div_cnt: '0,
		phase: ssw_pkg::PH_HOLD,
		str_cnt: '0,
		wd_cnt: '0,
		kick_prev: ssw_pkg::KICK_MID,
		out: '{reset_n: 1'h0, reset: 1'h1, fault_n: 1'h1, flag_n: 1'h0,
			cs_n: 1'h1, backup: 1'h0, low_line_n: 1'h0}
	};

	ssw_pkg::ssw_state_type st_reg;
	ssw_pkg::ssw_state_type st_next;
	logic [`SSW_SYNC_W-1:0] raw_in;
	logic [`SSW_SYNC_W-1:0] agree;
	logic int_tick;
	logic ext_tick;
	logic tick;
	logic ll_ok;
	ssw_pkg::ssw_kick_type kick_now;
	logic kick_edge;

	always_comb begin
		raw_in = '0;
		raw_in[`SSW_IX_LL] = low_line_sense_ok_i;
		raw_in[`SSW_IX_PF] = supply_fail_sense_ok_i;
		raw_in[`SSW_IX_MAIN] = main_above_backup_cell_i;
		raw_in[`SSW_IX_KHI] = watchdog_kick_in_hi_i;
		raw_in[`SSW_IX_KLO] = watchdog_kick_in_lo_i;
		raw_in[`SSW_IX_TSEL] = timebase_select_i;
		raw_in[`SSW_IX_EXT] = external_timebase_in_i;
		raw_in[`SSW_IX_CS] = chip_select_n_i;
	end

	// Only the settled copy is used downstream; stage one feeds stage two alone
	assign agree = ~(st_reg.s2 ^ st_reg.s3);
	assign int_tick = (st_reg.div_cnt == INT_DIV - `SSW_DIV_W'(1));
	assign ext_tick = st_reg.stab[`SSW_IX_EXT] && !st_reg.ext_prev;
	// Open select pin reads high through its pull-up, so internal is the default
	assign tick = st_reg.stab[`SSW_IX_TSEL] ? int_tick : ext_tick;
	assign ll_ok = st_reg.stab[`SSW_IX_LL];
	assign kick_now = kick_level(st_reg.stab[`SSW_IX_KHI], st_reg.stab[`SSW_IX_KLO]);
	assign kick_edge = (kick_now != st_reg.kick_prev);

	always_comb begin
		st_next = st_reg;
		st_next.s1 = raw_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		st_next.stab = (agree & st_reg.s3) | (~agree & st_reg.stab);
		st_next.ext_prev = st_reg.stab[`SSW_IX_EXT];
		st_next.div_cnt = int_tick ? '0 : st_reg.div_cnt + `SSW_DIV_W'(1);
		st_next.kick_prev = kick_now;
		if (kick_edge) begin
			st_next.out.fault_n = 1'h1;
		end
		unique case (st_reg.phase)
			ssw_pkg::PH_HOLD: begin
				st_next.str_cnt = '0;
				if (ll_ok) begin
					st_next.phase = ssw_pkg::PH_STRETCH;
				end
			end
			ssw_pkg::PH_STRETCH, ssw_pkg::PH_WDPULSE: begin
				// Power-up stretch and watchdog pulse share one length
				if (tick) begin
					if (st_reg.str_cnt == STRETCH_TICKS - `SSW_STR_W'(1)) begin
						st_next.phase = ssw_pkg::PH_RUN;
						st_next.wd_cnt = '0;
						st_next.str_cnt = '0;
					end else begin
						st_next.str_cnt = st_reg.str_cnt + `SSW_STR_W'(1);
					end
				end
			end
			ssw_pkg::PH_RUN: begin
				if (kick_now == ssw_pkg::KICK_MID || kick_edge) begin
					st_next.wd_cnt = '0;
				end else if (tick) begin
					if (st_reg.wd_cnt == WD_TIMEOUT_TICKS - `SSW_WD_W'(1)) begin
						st_next.phase = ssw_pkg::PH_WDPULSE;
						st_next.out.fault_n = 1'h0;
						st_next.wd_cnt = '0;
						st_next.str_cnt = '0;
					end else begin
						st_next.wd_cnt = st_reg.wd_cnt + `SSW_WD_W'(1);
					end
				end
			end
		endcase
		if (!ll_ok) begin
			st_next.phase = ssw_pkg::PH_HOLD;
			st_next.out.fault_n = 1'h1;
		end
		st_next.out.reset_n = (st_next.phase == ssw_pkg::PH_RUN);
		st_next.out.reset = (st_next.phase != ssw_pkg::PH_RUN);
		st_next.out.flag_n = st_reg.stab[`SSW_IX_MAIN] && st_reg.stab[`SSW_IX_PF];
		// One cycle of gating latency is the price of registered outputs
		st_next.out.cs_n = ll_ok ? st_reg.stab[`SSW_IX_CS] : 1'h1;
		st_next.out.low_line_n = ll_ok;
		// Mixed comparator states keep the last choice, a simple hysteresis
		if (st_reg.stab[`SSW_IX_MAIN] && ll_ok) begin
			st_next.out.backup = 1'h0;
		end else if (!st_reg.stab[`SSW_IX_MAIN] && !ll_ok) begin
			st_next.out.backup = 1'h1;
		end
		if (sys_rst_i) begin
			st_next = RESET_STATE;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		st_reg <= st_next;
	end

	assign reset_n_o = st_reg.out.reset_n;
	assign reset_o = st_reg.out.reset;
	assign watchdog_fault_out_n_o = st_reg.out.fault_n;
	assign supply_fail_flag_n_o = st_reg.out.flag_n;
	assign chip_select_gated_n_o = st_reg.out.cs_n;
	assign backup_active_o = st_reg.out.backup;
	assign low_line_n_o = st_reg.out.low_line_n;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	property p_hold_low;
		!ll_ok |=> !reset_n_o && st_reg.phase == ssw_pkg::PH_HOLD;
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("reset not held on low line");

	property p_stretch_end;
		st_reg.phase == ssw_pkg::PH_STRETCH && tick && ll_ok
			&& st_reg.str_cnt == STRETCH_TICKS - `SSW_STR_W'(1) |=> reset_n_o;
	endproperty
	a_stretch_end: assert property (p_stretch_end) else $error("stretch did not end");

	property p_stretch_hold;
		st_reg.phase == ssw_pkg::PH_STRETCH && st_reg.str_cnt < STRETCH_TICKS - `SSW_STR_W'(1)
			|=> !reset_n_o;
	endproperty
	a_stretch_hold: assert property (p_stretch_hold) else $error("reset released early");

	property p_pulse_end;
		st_reg.phase == ssw_pkg::PH_WDPULSE && tick && ll_ok
			&& st_reg.str_cnt == STRETCH_TICKS - `SSW_STR_W'(1) |=> reset_n_o;
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("watchdog pulse length wrong");

	property p_fault_with_reset;
		$fell(watchdog_fault_out_n_o) |-> !reset_n_o && st_reg.phase == ssw_pkg::PH_WDPULSE;
	endproperty
	a_fault_with_reset: assert property (p_fault_with_reset) else $error("fault without reset");

	property p_kick_restart;
		st_reg.phase == ssw_pkg::PH_RUN && kick_edge && ll_ok |=> st_reg.wd_cnt == '0;
	endproperty
	a_kick_restart: assert property (p_kick_restart) else $error("kick did not restart");

	property p_mid_disable;
		st_reg.phase == ssw_pkg::PH_RUN && kick_now == ssw_pkg::KICK_MID
			|=> st_reg.wd_cnt == '0 && st_reg.phase != ssw_pkg::PH_WDPULSE;
	endproperty
	a_mid_disable: assert property (p_mid_disable) else $error("watchdog ran while open");

	property p_flag_follow;
		st_reg.stab[`SSW_IX_MAIN] |=> supply_fail_flag_n_o == $past(st_reg.stab[`SSW_IX_PF]);
	endproperty
	a_flag_follow: assert property (p_flag_follow) else $error("fail flag wrong");

	property p_flag_forced;
		!st_reg.stab[`SSW_IX_MAIN] |=> !supply_fail_flag_n_o;
	endproperty
	a_flag_forced: assert property (p_flag_forced) else $error("fail flag not forced");

	property p_cs_gate;
		ll_ok |=> chip_select_gated_n_o == $past(st_reg.stab[`SSW_IX_CS]);
	endproperty
	a_cs_gate: assert property (p_cs_gate) else $error("chip select not passed");

	property p_cs_block;
		!ll_ok |=> chip_select_gated_n_o;
	endproperty
	a_cs_block: assert property (p_cs_block) else $error("chip select not blocked");

	property p_backup_sel;
		!st_reg.stab[`SSW_IX_MAIN] && !ll_ok |=> backup_active_o;
	endproperty
	a_backup_sel: assert property (p_backup_sel) else $error("cell not selected");

	// Mixed comparator states must not drop the cell once it is chosen
	property p_backup_keep;
		backup_active_o && !(st_reg.stab[`SSW_IX_MAIN] && ll_ok) |=> backup_active_o;
	endproperty
	a_backup_keep: assert property (p_backup_keep) else $error("cell dropped early");

	property p_main_sel;
		st_reg.stab[`SSW_IX_MAIN] && ll_ok |=> !backup_active_o;
	endproperty
	a_main_sel: assert property (p_main_sel) else $error("main not selected");

	property p_fault_release;
		kick_edge || !ll_ok |=> watchdog_fault_out_n_o;
	endproperty
	a_fault_release: assert property (p_fault_release) else $error("fault not released");

	property p_inverse;
		reset_o == !reset_n_o;
	endproperty
	a_inverse: assert property (p_inverse) else $error("reset outputs not inverse");

	property p_tick_sel;
		!st_reg.stab[`SSW_IX_TSEL] && !ext_tick |-> !tick;
	endproperty
	a_tick_sel: assert property (p_tick_sel) else $error("wrong timebase");

	c_timeout: cover property ($fell(watchdog_fault_out_n_o));
	c_stretch_done: cover property ($rose(reset_n_o));
	c_backup: cover property ($rose(backup_active_o));
	c_ext_tick: cover property (!st_reg.stab[`SSW_IX_TSEL] && tick);

endmodule : ssw_supervisor
`default_nettype wire

// *** ssw_cpu_model.sv ***
// Processor model that services or neglects the three-level watchdog kick pin
`timescale 1ns/10ps
`default_nettype none

module ssw_cpu_model #(
	parameter int TOGGLE_CYCLES = 8
) (
	input wire logic sys_clk_i,
	input wire ssw_pkg::ssw_kick_type level_i,
	input wire logic service_i,
	output logic kick_hi_o,
	output logic kick_lo_o
);
	int count_reg = 0;
	logic phase_reg = 1'b0;
	ssw_pkg::ssw_kick_type level;
	// Servicing toggles well inside the timeout, so no reset may follow
	always @(negedge sys_clk_i) begin
		count_reg <= (count_reg == TOGGLE_CYCLES - 1) ? 0 : count_reg + 1;
		if (count_reg == TOGGLE_CYCLES - 1) begin
			phase_reg <= ~phase_reg;
		end
	end
	assign level = service_i ? (phase_reg ? ssw_pkg::KICK_HIGH : ssw_pkg::KICK_LOW) : level_i;
	// Both comparators high is how a floating pin reads
	assign kick_hi_o = (level != ssw_pkg::KICK_LOW);
	assign kick_lo_o = (level != ssw_pkg::KICK_HIGH);
endmodule : ssw_cpu_model

`default_nettype wire

// *** test_ssw_supervisor.sv ***
// Self-checking bench for the supply supervisor and watchdog
`timescale 1ns/10ps
`default_nettype none

module test_ssw_supervisor;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic ll_ok = 1'b0;
	logic pf_ok = 1'b0;
	logic main_ok = 1'b0;
	logic tsel = 1'b1;
	logic ext = 1'b0;
	logic cs_n = 1'b1;
	logic service = 1'b0;
	ssw_pkg::ssw_kick_type level = ssw_pkg::KICK_MID;
	logic kick_hi;
	logic kick_lo;
	wire [6:0] outs;
	int num_errors = 0;
	int n_compared = 0;
	int lows;

	always #10 sys_clk_i = ~sys_clk_i;

	ssw_supervisor #(.INT_DIV(16'h0004), .STRETCH_TICKS(8'h03), .WD_TIMEOUT_TICKS(16'h0005))
	u_ssw_supervisor (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.low_line_sense_ok_i(ll_ok), .supply_fail_sense_ok_i(pf_ok),
		.main_above_backup_cell_i(main_ok),
		.watchdog_kick_in_hi_i(kick_hi), .watchdog_kick_in_lo_i(kick_lo),
		.timebase_select_i(tsel), .external_timebase_in_i(ext), .chip_select_n_i(cs_n),
		.reset_n_o(outs[0]), .reset_o(outs[1]), .watchdog_fault_out_n_o(outs[2]),
		.supply_fail_flag_n_o(outs[3]), .chip_select_gated_n_o(outs[4]),
		.backup_active_o(outs[5]), .low_line_n_o(outs[6])
	);

	ssw_cpu_model u_ssw_cpu_model (
		.sys_clk_i(sys_clk_i), .level_i(level), .service_i(service),
		.kick_hi_o(kick_hi), .kick_lo_o(kick_lo)
	);

	task automatic check(input logic seen, input logic exp, input string name);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %b seen %b", name, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : cyc

	// Bounded wait so a stuck output fails instead of hanging the run
	task automatic wait_out(input int i, input logic v, input int max, input string name);
		int k;
		k = 0;
		while (outs[i] !== v && k < max) begin
			@(negedge sys_clk_i);
			k++;
		end
		check(outs[i], v, name);
	endtask : wait_out

	task automatic count_low(input int n);
		lows = 0;
		repeat (n) begin
			@(negedge sys_clk_i);
			if (outs[0] !== 1'b1) begin
				lows++;
			end
		end
	endtask : count_low

	task automatic t_power_up;
		check(outs[0], 1'b0, "reset_n held");
		ll_ok = 1'b1;
		cyc(11);
		check(outs[0], 1'b0, "reset_n stretched");
		check(outs[1], 1'b1, "reset high");
		wait_out(0, 1'b1, 20, "reset_n released");
		check(outs[1], 1'b0, "reset low");
	endtask : t_power_up

	task automatic t_supply;
		for (int i = 0; i < 4; i++) begin
			main_ok = i[1];
			pf_ok = i[0];
			cyc(6);
			check(outs[3], i[1] & i[0], "flag_n");
		end
		check(outs[5], 1'b0, "backup off");
		cs_n = 1'b0;
		cyc(6);
		check(outs[4], 1'b0, "cs pass low");
		cs_n = 1'b1;
		cyc(6);
		check(outs[4], 1'b1, "cs pass high");
		cs_n = 1'b0;
	endtask : t_supply

	task automatic t_watchdog;
		service = 1'b1;
		count_low(120);
		check(lows == 0, 1'b1, "serviced no reset");
		service = 1'b0;
		level = ssw_pkg::KICK_HIGH;
		wait_out(0, 1'b0, 40, "timeout reset");
		check(outs[2], 1'b0, "fault low");
		check(outs[1], 1'b1, "reset pulse high");
		wait_out(0, 1'b1, 20, "pulse ends");
		check(outs[2], 1'b0, "fault held");
		level = ssw_pkg::KICK_LOW;
		wait_out(2, 1'b1, 6, "fault released by kick");
		wait_out(0, 1'b0, 40, "steady low timeout");
		check(outs[2], 1'b0, "fault low again");
		ll_ok = 1'b0;
		wait_out(2, 1'b1, 6, "fault released by low line");
		check(outs[6], 1'b0, "low_line_n");
		check(outs[4], 1'b1, "cs forced high");
		main_ok = 1'b0;
		wait_out(5, 1'b1, 6, "backup on");
		check(outs[3], 1'b0, "flag forced low");
	endtask : t_watchdog

	task automatic t_mid;
		level = ssw_pkg::KICK_MID;
		main_ok = 1'b1;
		ll_ok = 1'b1;
		wait_out(0, 1'b1, 30, "reset after recovery");
		check(outs[5], 1'b0, "backup off again");
		count_low(150);
		check(lows == 0, 1'b1, "mid no reset");
		check(outs[2], 1'b1, "mid no fault");
	endtask : t_mid

	// External timebase: nothing advances until the external pin toggles
	task automatic t_ext;
		tsel = 1'b0;
		ll_ok = 1'b0;
		wait_out(0, 1'b0, 6, "reset on low line");
		ll_ok = 1'b1;
		cyc(40);
		check(outs[0], 1'b0, "no ticks no release");
		repeat (2) begin
			ext = 1'b1;
			cyc(3);
			ext = 1'b0;
			cyc(3);
		end
		check(outs[0], 1'b0, "two ticks no release");
		repeat (2) begin
			ext = 1'b1;
			cyc(3);
			ext = 1'b0;
			cyc(3);
		end
		wait_out(0, 1'b1, 8, "external release");
	endtask : t_ext

	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	initial begin
		cyc(10);
		sys_rst_i = 1'b0;
		t_power_up();
		t_supply();
		t_watchdog();
		t_mid();
		t_ext();
		finish_test();
	end

	initial begin
		#200us;
		num_errors++;
		finish_test();
	end
endmodule : test_ssw_supervisor

`default_nettype wire
